// File: hdl/plc_pkg.sv
/*
  Constants, register map and state type of the PHY link and
  energy-efficient control block.
  Assumes a 250 MHz system clock; all times become cycles here.
*/
`default_nettype none

package plc_pkg;

  // ********************************************************
  // Clocking and latency
  // ********************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int SYNC_CYC = 3;
  localparam int LAT_W = 10;
  localparam int LPI_CNT_W = 23;

  function automatic int cyc_ceil(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int TX_LAT_100_NS = 105;
  localparam int TX_LAT_10S_NS = 1350;
  localparam int TX_LAT_10M_NS = 1300;
  localparam int RX_LAT_100S_NS = 350;
  localparam int RX_LAT_100M_NS = 325;
  localparam int RX_LAT_10_NS = 2150;
  // Tx counts start at the synchronised edge, so the sync delay is removed
  localparam int TX_LAT_100_CYC = cyc_ceil(TX_LAT_100_NS) - SYNC_CYC;
  localparam int TX_LAT_10S_CYC = cyc_ceil(TX_LAT_10S_NS) - SYNC_CYC;
  localparam int TX_LAT_10M_CYC = cyc_ceil(TX_LAT_10M_NS) - SYNC_CYC;
  localparam int RX_LAT_100S_CYC = cyc_ceil(RX_LAT_100S_NS);
  localparam int RX_LAT_100M_CYC = cyc_ceil(RX_LAT_100M_NS);
  localparam int RX_LAT_10_CYC = cyc_ceil(RX_LAT_10_NS);

  localparam int LPI_QUIET_US = 20000;
  localparam int LPI_REFRESH_US = 200;
  localparam int LPI_QUIET_CYC = LPI_QUIET_US * 1000 / CLK_PERIOD_NS;
  localparam int LPI_REFRESH_CYC = LPI_REFRESH_US * 1000 / CLK_PERIOD_NS;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [13:0] IDX_BASIC_MODE = 14'h0000;
  localparam logic [13:0] IDX_MMD_CTRL = 14'h000d;
  localparam logic [13:0] IDX_MMD_DATA = 14'h000e;
  localparam logic [13:0] IDX_LINK_STATUS = 14'h0010;
  localparam logic [13:0] IDX_PHY_CTRL = 14'h0019;
  localparam logic [13:0] IDX_EEE_CFG3 = 14'h04d1;

  localparam int BMC_RESTART = 9;
  localparam int BMC_AN_EN = 12;
  localparam int BMC_SPEED = 13;
  localparam logic [15:0] BMC_WR_MASK = 16'hfdff;
  localparam int PHC_FORCE_CROSS = 14;
  localparam int PHC_MDIX_AUTO = 15;
  localparam int EC3_BYPASS_A = 0;
  localparam int EC3_BYPASS_B = 3;
  localparam int EC3_FORCE_LPI = 12;
  localparam int ST_TX_DROP = 6;

  localparam logic [15:0] BASIC_MODE_RST = 16'h3000;
  localparam logic [15:0] PHY_CTRL_RST = 16'h8000;
  localparam logic [15:0] EEE_CFG3_RST = 16'h0009;

  // ********************************************************
  // Indirect MMD space
  // ********************************************************
  localparam logic [1:0] MMD_FN_ADDR = 2'b00;
  localparam logic [4:0] DEVAD_PCS = 5'h03;
  localparam logic [4:0] DEVAD_AN = 5'h07;
  localparam logic [15:0] MMD_PCS_CTRL = 16'h1014;
  localparam logic [15:0] MMD_PCS_STAT = 16'h1001;
  localparam logic [15:0] MMD_PCS_CAP = 16'h1016;
  localparam logic [15:0] MMD_AN_ADV = 16'h203c;
  localparam logic [15:0] MMD_AN_LP = 16'h203d;
  localparam int MMD7_ADV_BIT = 1;
  localparam int PCS_STAT_LPI_BIT = 9;
  localparam logic [15:0] PCS_CAP_VAL = 16'h0002;

  typedef enum logic [2:0] {
    AN_IDLE, AN_MDIX, AN_FLP, AN_NP_FMT, AN_NP_UNF, AN_LINK
  } plc_an_state_type;

endpackage

`default_nettype wire

// File: hdl/plc_phy_link_ctrl.sv
/*
  Link bring-up, cable crossover, energy-efficient negotiation,
  register-driven low power idle and RMII latency timing of a
  10/100 PHY, with its registers on an Avalon-MM slave.
  Assumes the analog front end gives same-clock pulses and levels;
  straps and the RMII transmit enable are asynchronous pins.
*/
// Local design decision: the Avalon-MM interface to the registers.
// Notes on behaviour
// - pick highest speed both sides advertise
// - exchange abilities with fast link pulse bursts
// - negotiation enable from strap or control bit
// - renegotiate at power up, command, failure, change
// - detect cable type and swap pair roles
// - crossover resolved before exchange; also when forced
// - auto crossover enable from strap or bit
// - forced pair assignment when auto is off
// - low power idle at both speeds, 10M reduced
// - energy saving only when both sides agree
// - send formatted then unformatted next page
// - energy registers live in MMD3 and MMD7
// - bypassed at reset; software clears bypass, advertises
// - idle and refresh driven from register control
// - frames arriving during idle are dropped
// - transmit enable to delimiter latency fixed
// - delimiter to carrier-valid latency fixed
// - config bit twelve forces idle on, off
// - restart bit renegotiates with new advertisement
`default_nettype none

module plc_phy_link_ctrl
  import plc_pkg::*;
#(
  parameter int QUIET_CYCLES = LPI_QUIET_CYC,
  parameter int REFRESH_CYCLES = LPI_REFRESH_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEnable,
  // Avalon-MM slave
  input wire logic [15:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Strap pins
  input wire logic strapAnEnable,
  input wire logic strapMdixAuto,
  input wire logic strapRmiiMaster,
  // Analog front end
  input wire logic crossDetect,
  input wire logic lpPageValid,
  input wire logic lpAbility100,
  input wire logic lpEeeAbility,
  input wire logic npAck,
  input wire logic linkFail,
  input wire logic rxCarrier,
  // RMII side
  input wire logic rmiiTxEn,
  output logic crsDv,
  // Line side control
  output logic mdixSwap,
  output logic flpBurst,
  output logic npSendFormatted,
  output logic npSendUnformatted,
  output logic ssdTx,
  // Link state
  output logic linkUp,
  output logic speed100,
  output logic eeeActive,
  output logic lpiIdle,
  output logic lpiRefresh,
  output logic lpiAmpReduced
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic mmd_hit(input logic [4:0] dev,
    input logic [15:0] adr, input logic [4:0] wantDev,
    input logic [15:0] wantAdr);
    return (dev == wantDev) && (adr == wantAdr);
  endfunction

  function automatic logic [LAT_W-1:0] lat_load(input int cyc);
    return LAT_W'(cyc - 1);
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  plc_an_state_type anState;
  logic ackQ;
  logic [15:0] bmc, phc, ec3, mmdCtl, mmdAddr, mmd7Adv, mmd3Ctrl;
  logic [2:0] strapSync1, strapSync2;
  logic [1:0] strapCnt;
  logic masterMode, lpEeeQ, txDropped, rxCarrierQ;
  logic txSync1, txSync2, txSync3;
  logic [LAT_W-1:0] txCnt, rxCnt;
  logic [LPI_CNT_W-1:0] lpiCnt;

  // ********************************************************
  // Bus decode
  // ********************************************************
  wire logic [13:0] regIdx = avsAddress[15:2];
  wire logic wrEn = avsWrite && ackQ && clkEnable;
  wire logic [15:0] wd = avsWriteData[15:0];
  wire logic wrBmc = wrEn && (regIdx == IDX_BASIC_MODE);
  wire logic wrPhc = wrEn && (regIdx == IDX_PHY_CTRL);
  wire logic wrEc3 = wrEn && (regIdx == IDX_EEE_CFG3);
  wire logic wrCtl = wrEn && (regIdx == IDX_MMD_CTRL);
  wire logic wrDat = wrEn && (regIdx == IDX_MMD_DATA);
  wire logic wrSts = wrEn && (regIdx == IDX_LINK_STATUS);
  wire logic [4:0] mmdDev = mmdCtl[4:0];
  wire logic mmdDataFn = mmdCtl[15:14] != MMD_FN_ADDR;
  wire logic wrMmd = wrDat && mmdDataFn;
  wire logic hitAdv = mmd_hit(mmdDev, mmdAddr, DEVAD_AN, MMD_AN_ADV);
  wire logic hitPcsCtl = mmd_hit(mmdDev, mmdAddr, DEVAD_PCS,
    MMD_PCS_CTRL);

  // Indirect MMD readback
  wire logic [15:0] mmdRead =
    hitAdv ? mmd7Adv :
    hitPcsCtl ? mmd3Ctrl :
    mmd_hit(mmdDev, mmdAddr, DEVAD_PCS, MMD_PCS_STAT) ?
      16'(lpiIdle) << PCS_STAT_LPI_BIT :
    mmd_hit(mmdDev, mmdAddr, DEVAD_PCS, MMD_PCS_CAP) ? PCS_CAP_VAL :
    mmd_hit(mmdDev, mmdAddr, DEVAD_AN, MMD_AN_LP) ?
      16'(lpEeeQ) << MMD7_ADV_BIT : 16'h0000;

  wire logic [15:0] statusWord = {9'h000, txDropped, lpiIdle,
    masterMode, mdixSwap, eeeActive, speed100, linkUp};

  wire logic [15:0] rdMux =
    (regIdx == IDX_BASIC_MODE) ? bmc :
    (regIdx == IDX_PHY_CTRL) ? phc :
    (regIdx == IDX_EEE_CFG3) ? ec3 :
    (regIdx == IDX_MMD_CTRL) ? mmdCtl :
    (regIdx == IDX_MMD_DATA) ? (mmdDataFn ? mmdRead : mmdAddr) :
    (regIdx == IDX_LINK_STATUS) ? statusWord : 16'h0000;

  // One wait state: request taken, answered the next enabled edge
  assign avsWaitRequest = !(ackQ && clkEnable);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ackQ <= 1'b0;
      avsReadData <= 32'h0000_0000;
    end else if (clkEnable) begin
      ackQ <= (avsRead || avsWrite) && !ackQ;
      if (avsRead && !ackQ) begin
        avsReadData <= {16'h0000, rdMux};
      end
    end
  end

  // ********************************************************
  // Straps, caught after reset release
  // ********************************************************
  wire logic strapLoad = (strapCnt == 2'd2);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strapSync1 <= 3'h0;
      strapSync2 <= 3'h0;
      strapCnt <= 2'd0;
      masterMode <= 1'b0;
    end else if (clkEnable) begin
      strapSync1 <= {strapRmiiMaster, strapMdixAuto, strapAnEnable};
      strapSync2 <= strapSync1;
      if (strapCnt != 2'd3) begin
        strapCnt <= strapCnt + 2'd1;
      end
      if (strapLoad) begin
        masterMode <= strapSync2[2];
      end
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bmc <= BASIC_MODE_RST;
      phc <= PHY_CTRL_RST;
      ec3 <= EEE_CFG3_RST;
      mmdCtl <= 16'h0000;
      mmdAddr <= 16'h0000;
      mmd7Adv <= 16'h0000;
      mmd3Ctrl <= 16'h0000;
    end else if (clkEnable) begin
      if (strapLoad) begin
        bmc[BMC_AN_EN] <= strapSync2[0];
        phc[PHC_MDIX_AUTO] <= strapSync2[1];
      end else begin
        if (wrBmc) bmc <= wd & BMC_WR_MASK;
        if (wrPhc) phc <= wd;
      end
      if (wrEc3) ec3 <= wd;
      if (wrCtl) mmdCtl <= wd;
      if (wrDat && !mmdDataFn) mmdAddr <= wd;
      if (wrMmd && hitAdv) mmd7Adv <= wd;
      if (wrMmd && hitPcsCtl) mmd3Ctrl <= wd;
    end
  end

  // ********************************************************
  // Negotiation
  // ********************************************************
  wire logic anEn = bmc[BMC_AN_EN];
  wire logic restartWr = wrBmc && wd[BMC_RESTART];
  wire logic eeeAdvertise = !ec3[EC3_BYPASS_A] && !ec3[EC3_BYPASS_B]
    && mmd7Adv[MMD7_ADV_BIT];
  wire logic mdixPick = phc[PHC_MDIX_AUTO] ? crossDetect
    : phc[PHC_FORCE_CROSS];
  // Power up, command, failure and a change of mode
  wire logic startReq = strapLoad || restartWr
    || (wrBmc && (wd[BMC_AN_EN] != anEn))
    || (linkFail && anState == AN_LINK);

  assign flpBurst = (anState == AN_FLP);
  assign npSendFormatted = (anState == AN_NP_FMT);
  assign npSendUnformatted = (anState == AN_NP_UNF);
  assign linkUp = (anState == AN_LINK);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      anState <= AN_IDLE;
      mdixSwap <= 1'b0;
      speed100 <= 1'b0;
      lpEeeQ <= 1'b0;
    end else if (clkEnable) begin
      if (startReq) begin
        anState <= AN_MDIX;
        lpEeeQ <= 1'b0;
      end else begin
        case (anState)
          AN_MDIX: begin
            mdixSwap <= mdixPick;
            if (anEn) begin
              anState <= AN_FLP;
            end else begin
              speed100 <= bmc[BMC_SPEED];
              anState <= AN_LINK;
            end
          end
          AN_FLP: begin
            if (lpPageValid) begin
              speed100 <= lpAbility100;
              anState <= eeeAdvertise ? AN_NP_FMT : AN_LINK;
            end
          end
          AN_NP_FMT: begin
            if (npAck) anState <= AN_NP_UNF;
          end
          AN_NP_UNF: begin
            if (npAck) begin
              lpEeeQ <= lpEeeAbility;
              anState <= AN_LINK;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ********************************************************
  // Low power idle
  // ********************************************************
  wire logic eeeNext = linkUp && anEn && lpEeeQ && eeeAdvertise;
  wire logic lpiForce = ec3[EC3_FORCE_LPI] && eeeActive && linkUp;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eeeActive <= 1'b0;
      lpiIdle <= 1'b0;
      lpiAmpReduced <= 1'b0;
      lpiRefresh <= 1'b0;
      lpiCnt <= '0;
    end else if (clkEnable) begin
      eeeActive <= eeeNext;
      lpiIdle <= lpiForce;
      lpiAmpReduced <= eeeActive && !speed100;
      if (!lpiForce) begin
        lpiRefresh <= 1'b0;
        lpiCnt <= LPI_CNT_W'(QUIET_CYCLES - 1);
      end else if (lpiCnt == '0) begin
        lpiRefresh <= !lpiRefresh;
        lpiCnt <= lpiRefresh ? LPI_CNT_W'(QUIET_CYCLES - 1)
          : LPI_CNT_W'(REFRESH_CYCLES - 1);
      end else begin
        lpiCnt <= lpiCnt - 1'b1;
      end
    end
  end

  // ********************************************************
  // Transmit and receive latency
  // ********************************************************
  wire logic txRise = txSync2 && !txSync3;
  wire logic rxRise = rxCarrier && !rxCarrierQ;
  wire logic [LAT_W-1:0] txLoad = speed100 ? lat_load(TX_LAT_100_CYC)
    : masterMode ? lat_load(TX_LAT_10M_CYC) : lat_load(TX_LAT_10S_CYC);
  wire logic [LAT_W-1:0] rxLoad = !speed100 ? lat_load(RX_LAT_10_CYC)
    : masterMode ? lat_load(RX_LAT_100M_CYC)
    : lat_load(RX_LAT_100S_CYC);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txSync1 <= 1'b0;
      txSync2 <= 1'b0;
      txSync3 <= 1'b0;
      rxCarrierQ <= 1'b0;
      txCnt <= '0;
      rxCnt <= '0;
      ssdTx <= 1'b0;
      crsDv <= 1'b0;
      txDropped <= 1'b0;
    end else if (clkEnable) begin
      txSync1 <= rmiiTxEn;
      txSync2 <= txSync1;
      txSync3 <= txSync2;
      rxCarrierQ <= rxCarrier;
      ssdTx <= (txCnt == LAT_W'(1));
      if (txRise && !lpiIdle) begin
        txCnt <= txLoad;
      end else if (txCnt != '0) begin
        txCnt <= txCnt - 1'b1;
      end
      // No frame store during idle; set wins over clear
      txDropped <= (txDropped && !(wrSts && wd[ST_TX_DROP]))
        || (txRise && lpiIdle);
      if (rxRise) begin
        rxCnt <= rxLoad;
      end else if (rxCnt != '0) begin
        rxCnt <= rxCnt - 1'b1;
      end
      if (!rxCarrier) begin
        crsDv <= 1'b0;
      end else if (rxCnt == LAT_W'(1)) begin
        crsDv <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  localparam int A_TX100 = TX_LAT_100_CYC;
  localparam int A_RX100S = RX_LAT_100S_CYC;

  property p_speed_resolve;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    anState == AN_FLP && lpPageValid && !startReq |=>
      speed100 == $past(lpAbility100) && linkUp != eeeAdvertise;
  endproperty
  a_speed_resolve: assert property (p_speed_resolve)
    else $error("resolved speed does not follow partner ability");

  property p_flp_enabled;
    @(posedge clk_sys) disable iff (rst)
    flpBurst |-> anEn;
  endproperty
  a_flp_enabled: assert property (p_flp_enabled)
    else $error("pulse bursts sent with negotiation disabled");

  property p_restart;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    restartWr && wd[BMC_AN_EN] && anEn && !strapLoad |=>
      anState == AN_MDIX ##1 flpBurst;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not renegotiate");

  property p_mdix_pick;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    anState == AN_MDIX && !startReq |=> mdixSwap == $past(mdixPick);
  endproperty
  a_mdix_pick: assert property (p_mdix_pick)
    else $error("pair assignment not taken from cable or forced bit");

  property p_mdix_first;
    @(posedge clk_sys) disable iff (rst)
    $rose(flpBurst) |-> $past(anState) == AN_MDIX;
  endproperty
  a_mdix_first: assert property (p_mdix_first)
    else $error("exchange began before crossover resolution");

  property p_eee_agree;
    @(posedge clk_sys) disable iff (rst)
    eeeActive |-> $past(lpEeeQ && linkUp && eeeAdvertise);
  endproperty
  a_eee_agree: assert property (p_eee_agree)
    else $error("energy saving active without agreement");

  property p_np_order;
    @(posedge clk_sys) disable iff (rst)
    $rose(npSendUnformatted) |-> $past(npSendFormatted);
  endproperty
  a_np_order: assert property (p_np_order)
    else $error("unformatted page not after formatted page");

  property p_drop;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    txRise && lpiIdle |=> txDropped ##1 !ssdTx;
  endproperty
  a_drop: assert property (p_drop)
    else $error("frame during idle not dropped");

  property p_tx_latency;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    txRise && !lpiIdle && speed100 |-> ##A_TX100 ssdTx;
  endproperty
  a_tx_latency: assert property (p_tx_latency)
    else $error("transmit latency wrong at 100M");

  property p_rx_latency;
    @(posedge clk_sys) disable iff (rst || !clkEnable)
    rxRise && speed100 && !masterMode |->
      ##A_RX100S (crsDv || !rxCarrier);
  endproperty
  a_rx_latency: assert property (p_rx_latency)
    else $error("receive latency wrong at 100M slave");

  property p_lpi_force;
    @(posedge clk_sys) disable iff (rst)
    $rose(lpiIdle) |-> $past(ec3[EC3_FORCE_LPI] && eeeActive);
  endproperty
  a_lpi_force: assert property (p_lpi_force)
    else $error("idle forced without control bit and agreement");

  c_eee_up: cover property (@(posedge clk_sys) $rose(eeeActive));
  c_refresh: cover property (@(posedge clk_sys) $rose(lpiRefresh));
  c_tx_drop: cover property (@(posedge clk_sys) $rose(txDropped));
  c_ssd: cover property (@(posedge clk_sys) ssdTx);

endmodule

`default_nettype wire

// File: tb/plc_link_partner.sv
/*
  Far-end PHY model: answers pages and next pages after a delay.
  Assumes same-clock pulses as the device's front end expects.
*/
`default_nettype none

module plc_link_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Behaviour set by the bench
  input wire logic [7:0] respDelay,
  input wire logic ability100,
  input wire logic eeeAbility,
  // Device line-side control
  input wire logic flpBurst,
  input wire logic npSendFormatted,
  input wire logic npSendUnformatted,
  // Partner answers
  output logic lpPageValid,
  output logic lpAbility100,
  output logic lpEeeAbility,
  output logic npAck
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************
  // Page answers
  // ********************************************************
  logic [7:0] waitCnt;
  wire logic anyPage = flpBurst | npSendFormatted | npSendUnformatted;
  wire logic busy = lpPageValid | npAck;
  wire logic go = anyPage && !busy && waitCnt == respDelay;

  always_ff @(posedge clk_sys) begin
    if (rst || !anyPage || busy || go) begin
      waitCnt <= 8'h00;
    end else begin
      waitCnt <= waitCnt + 8'h01;
    end
    lpPageValid <= !rst && go && flpBurst;
    npAck <= !rst && go && !flpBurst;
  end

  // Abilities mean nothing away from their pulse
  assign lpAbility100 = lpPageValid ? ability100 : !ability100;
  assign lpEeeAbility = npAck ? eeeAbility : !eeeAbility;

endmodule

`default_nettype wire

// File: tb/plc_phy_link_ctrl_tb.sv
/*
  Self-checking bench of the PHY link control block.
  Assumes the partner model plc_link_partner.
*/
`default_nettype none

module plc_phy_link_ctrl_tb import plc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************
  // Signals
  // ********************************************************
  logic clk_sys = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
  logic rmiiTxEn = 1'b0, rxCarrier = 1'b0, crossDetect = 1'b0;
  logic linkFail = 1'b0, ability100 = 1'b1, hit = 1'b0;
  logic clkEnable = 1'b1, eeeAbility = 1'b1;
  logic [15:0] avsAddress = 16'h0000;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [7:0] respDelay = 8'h00;
  logic [31:0] avsReadData;
  logic [15:0] q;
  logic avsWaitRequest, crsDv, mdixSwap, flpBurst, npSendFormatted;
  logic npSendUnformatted, ssdTx, linkUp, speed100, eeeActive;
  logic lpiIdle, lpiRefresh, lpiAmpReduced, lpPageValid;
  logic lpAbility100, lpEeeAbility, npAck;
  int nMismatch = 0;
  int checksDone = 0;

  plc_phy_link_ctrl #(.QUIET_CYCLES(40), .REFRESH_CYCLES(8))
      i_plc_phy_link_ctrl (
    .clk_sys(clk_sys), .rst(rst), .clkEnable(clkEnable),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .strapAnEnable(1'b1),
    .strapMdixAuto(1'b1), .strapRmiiMaster(1'b0),
    .crossDetect(crossDetect), .lpPageValid(lpPageValid),
    .lpAbility100(lpAbility100), .lpEeeAbility(lpEeeAbility),
    .npAck(npAck), .linkFail(linkFail), .rxCarrier(rxCarrier),
    .rmiiTxEn(rmiiTxEn), .crsDv(crsDv), .mdixSwap(mdixSwap),
    .flpBurst(flpBurst), .npSendFormatted(npSendFormatted),
    .npSendUnformatted(npSendUnformatted), .ssdTx(ssdTx),
    .linkUp(linkUp), .speed100(speed100), .eeeActive(eeeActive),
    .lpiIdle(lpiIdle), .lpiRefresh(lpiRefresh),
    .lpiAmpReduced(lpiAmpReduced));

  plc_link_partner i_plc_link_partner (
    .clk_sys(clk_sys), .rst(rst), .respDelay(respDelay),
    .ability100(ability100), .eeeAbility(eeeAbility), .flpBurst(flpBurst),
    .npSendFormatted(npSendFormatted),
    .npSendUnformatted(npSendUnformatted), .lpPageValid(lpPageValid),
    .lpAbility100(lpAbility100), .lpEeeAbility(lpEeeAbility),
    .npAck(npAck));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic final_report();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic acc(input bit w, input logic [13:0] idx,
                     input logic [15:0] d);
    @(posedge clk_sys);
    avsAddress <= {idx, 2'b00};
    avsWriteData <= {16'h0000, d};
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
    q = avsReadData[15:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] idx, input logic [15:0] e,
                    input string nm);
    acc(1'b0, idx, 16'h0000);
    chk(nm, e, q);
  endtask

  // Points the indirect window at one MMD register
  task automatic mmd(input logic [4:0] dv, input logic [15:0] a);
    acc(1'b1, IDX_MMD_CTRL, {11'h000, dv});
    acc(1'b1, IDX_MMD_DATA, a);
    acc(1'b1, IDX_MMD_CTRL, {2'b01, 9'h000, dv});
  endtask

  task automatic relink();
    acc(1'b1, IDX_BASIC_MODE, 16'h3200);
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 3000 && linkUp !== 1'b1; i++) @(posedge clk_sys);
    // Registered status follows the link state by up to two cycles
    repeat (2) @(posedge clk_sys);
    chk("linkUp", 16'h0001, {15'h0000, linkUp});
  endtask

  // Cycles from a stimulus edge to the answering output
  task automatic lat(input bit rx, input int e, input string nm);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (rx) rxCarrier <= 1'b1;
    else rmiiTxEn <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (n < 900 && (rx ? crsDv : ssdTx) !== 1'b1);
    chk(nm, 16'h0001, {15'h0000, n >= e && n <= e + 2});
    @(posedge clk_sys);
    rxCarrier <= 1'b0;
    rmiiTxEn <= 1'b0;
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_BASIC_MODE, 16'h3000, "basicMode");
    rd(IDX_PHY_CTRL, 16'h8000, "phyCtrl");
    rd(IDX_EEE_CFG3, 16'h0009, "energy_efficient_config_three");
    rd(14'h0123, 16'h0000, "unmapped");
    relink();
    chk("speed100", 16'h0001, {15'h0000, speed100});
    chk("eeeBypass", 16'h0000, {15'h0000, eeeActive});
    acc(1'b1, IDX_EEE_CFG3, 16'h0000);
    mmd(DEVAD_AN, MMD_AN_ADV);
    acc(1'b1, IDX_MMD_DATA, 16'h0002);
    mmd(DEVAD_PCS, MMD_PCS_CAP);
    rd(IDX_MMD_DATA, 16'h0002, "pcsCap");
    respDelay <= 8'h14;
    relink();
    chk("eeeActive", 16'h0001, {15'h0000, eeeActive});
    rd(IDX_LINK_STATUS, 16'h0007, "status");
    lat(1'b0, 27, "tx100");
    lat(1'b1, 88, "rx100");
    acc(1'b1, IDX_EEE_CFG3, 16'h1000);
    for (int i = 0; i < 200 && lpiRefresh !== 1'b1; i++) @(posedge clk_sys);
    chk("lpiRefresh", 16'h0001, {15'h0000, lpiRefresh});
    mmd(DEVAD_PCS, MMD_PCS_STAT);
    rd(IDX_MMD_DATA, 16'h0200, "pcsStat");
    rmiiTxEn <= 1'b1;
    repeat (60) begin
      @(negedge clk_sys);
      if (ssdTx === 1'b1) hit = 1'b1;
    end
    @(posedge clk_sys);
    rmiiTxEn <= 1'b0;
    chk("droppedTx", 16'h0000, {15'h0000, hit});
    rd(IDX_LINK_STATUS, 16'h0067, "dropFlag");
    acc(1'b1, IDX_LINK_STATUS, 16'h0040);
    rd(IDX_LINK_STATUS, 16'h0027, "dropClear");
    acc(1'b1, IDX_EEE_CFG3, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk("lpiOff", 16'h0000, {15'h0000, lpiIdle});
    ability100 <= 1'b0;
    relink();
    chk("speed10", 16'h0000, {15'h0000, speed100});
    chk("ampLow", 16'h0001, {15'h0000, lpiAmpReduced});
    lat(1'b0, 338, "tx10");
    lat(1'b1, 538, "rx10");
    acc(1'b1, IDX_PHY_CTRL, 16'h4000);
    relink();
    chk("forcedCross", 16'h0001, {15'h0000, mdixSwap});
    crossDetect <= 1'b1;
    acc(1'b1, IDX_PHY_CTRL, 16'h8000);
    relink();
    chk("autoCross", 16'h0001, {15'h0000, mdixSwap});
    crossDetect <= 1'b0;
    relink();
    chk("autoStraight", 16'h0000, {15'h0000, mdixSwap});
    acc(1'b1, IDX_BASIC_MODE, 16'h0000);
    repeat (4) @(posedge clk_sys);
    chk("forcedLink", 16'h0001, {15'h0000, linkUp});
    chk("forcedEee", 16'h0000, {15'h0000, eeeActive});
    relink();
    // A frozen block ignores a link failure
    clkEnable <= 1'b0;
    linkFail <= 1'b1;
    @(posedge clk_sys);
    linkFail <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("frozenLink", 16'h0001, {15'h0000, linkUp});
    clkEnable <= 1'b1;
    linkFail <= 1'b1;
    @(posedge clk_sys);
    linkFail <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("linkLost", 16'h0000, {15'h0000, linkUp});
    relink();
    eeeAbility <= 1'b0;
    relink();
    chk("lpNoEee", 16'h0000, {15'h0000, eeeActive});
    mmd(DEVAD_AN, MMD_AN_LP);
    rd(IDX_MMD_DATA, 16'h0000, "lpEeeAdv");
    final_report();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    nMismatch++;
    final_report();
  end

endmodule

`default_nettype wire
